// ---- pkg/uart_regs_pkg.sv ----
package uart_regs_pkg;
  // Channel register offsets on the 4-bit address
  localparam logic [3:0] OFS_DATA     = 4'h0;
  localparam logic [3:0] OFS_IER      = 4'h1;
  localparam logic [3:0] OFS_ISR      = 4'h2;
  localparam logic [3:0] OFS_LINE_CTL = 4'h3;
  localparam logic [3:0] OFS_MODEM_CT = 4'h4;
  localparam logic [3:0] OFS_LINE_ST  = 4'h5;
  localparam logic [3:0] OFS_MODEM_ST = 4'h6;
  localparam logic [3:0] OFS_SCRATCH  = 4'h7;
  localparam logic [3:0] OFS_FEATURE  = 4'h8;
  localparam logic [3:0] OFS_ENH_FUNC = 4'h9;
  localparam logic [3:0] OFS_RSVD     = 4'ha;

  // Field positions
  localparam int LCR_DLAB_BIT  = 7;
  localparam int EFR_ENH_BIT   = 4;
  localparam int MCR_LOOP_BIT  = 4;
  localparam int FCR_EN_BIT    = 0;
  localparam int FCR_RXRST_BIT = 1;
  localparam int FCR_TXRST_BIT = 2;

  // Writable-bit masks
  localparam logic [7:0] IER_MASK     = 8'hef;
  localparam logic [7:0] IER_ENH_MASK = 8'he0;
  localparam logic [7:0] ISR_ENH_MASK = 8'h30;
  localparam logic [7:0] FCR_MASK     = 8'hf9;
  localparam logic [7:0] FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] MCR_ENH_MASK = 8'hec;
  localparam logic [7:0] FRAC_MASK    = 8'h0f;
  localparam logic [7:0] FEATURE_CONTROL_MASK    = 8'h30;
  localparam logic [7:0] R485_MASK    = 8'hfd;
  localparam logic [7:0] R485_ENH     = 8'hff;

  // Reset values
  localparam logic [7:0] DIV_LOW_RST  = 8'h00;
  localparam logic [7:0] DIV_HIGH_RST = 8'h00;
  localparam logic [7:0] DIV_FRAC_RST = 8'h00;
  localparam logic [7:0] IER_RST      = 8'h00;
  localparam logic [7:0] FCR_RST      = 8'h00;
  localparam logic [7:0] LCR_RST      = 8'h00;
  localparam logic [7:0] MCR_RST      = 8'h00;
  localparam logic [7:0] SPR_RST      = 8'h00;
  localparam logic [7:0] FEATURE_CONTROL_RST     = 8'h00;
  localparam logic [7:0] EFR_RST      = 8'h00;
  localparam logic [7:0] R485_RST     = 8'h00;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  // Data path buffering
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 8;

  // Host register access, one strobe per cycle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  // Receive error flags from the receiver
  typedef struct packed {
    logic fifo_err;
    logic rx_break;
    logic framing;
    logic parity;
    logic overrun;
  } line_flags_t;

  // Configuration handed to the channel logic
  typedef struct packed {
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] div_frac;
    logic [7:0] int_enable;
    logic [7:0] fifo_ctl;
    logic [7:0] line_ctl;
    logic [7:0] modem_ctl;
    logic [7:0] feature;
    logic [7:0] enh_func;
    logic [7:0] rs485_mode;
  } uart_cfg_t;
endpackage

// ---- hdl/uart_channel_register_map.sv ----
// Notes on behaviour
// - Offset 0 with divisor access clear reads receive data, writes transmit.
// - Divisor access set maps offsets 0,1,2 to divisor low, high, fraction.
// - Fraction register keeps bits 3:0; bits 7:4 read zero.
// - Offset 2 read gives FIFO enables, flow change, Xoff, source code.
// - Offset 2 write is FIFO control: enable, resets, DMA, triggers.
// - Enhanced bits act only with enhanced enable set, else read zero.
// - Interrupt enable bits: rx, tx, line, modem, bit4 zero, 7:5 enhanced.
// - Line control: length, stop, parity, even, forced, break, divisor.
// - Modem control: DTR, RTS, flow select, immediate, loop, any, IR, scale.
// - Line status read-only: ready, overrun, errors, break, empties, error.
// - Offset 7 is plain scratch storage without side effects.
// - Feature control keeps bit5 auto direction, bit4 IR invert only.
// - Enhanced function: flow mode, enable, special char, auto flow.
// - Modem control bits 2,3 drive no pins; used only in loopback.

// Synchronous FIFO with flush
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready  = (wr_ptr_q ^ rd_ptr_q) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_q != rd_ptr_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_q[AW-1:0]];

  // Storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge sys_clk) begin
    if (!rstn || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule // sync_fifo

// Register map and decode of one UART channel
module uart_channel_register_map (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rstn,
  // Host register access
  input  wire uart_regs_pkg::host_req_t  req,
  output logic                     [7:0] rd_data,
  output logic                           rd_valid,
  output logic                           thr_ready,
  // Transmit stream to the transmitter
  output logic                           tx_valid,
  input  wire logic                      tx_ready,
  output logic                     [7:0] tx_data,
  // Receive stream from the receiver
  input  wire logic                      rx_valid,
  output logic                           rx_ready,
  input  wire logic                [7:0] rx_data,
  // Status from the channel logic
  input  wire uart_regs_pkg::line_flags_t line_flags,
  input  wire logic                      tx_shift_empty,
  input  wire logic                [3:0] int_source,
  input  wire logic                      flow_change,
  input  wire logic                      xoff_special,
  // Modem pins, active low
  input  wire logic                      cts_n,
  input  wire logic                      dsr_n,
  input  wire logic                      ri_n,
  input  wire logic                      cd_n,
  output logic                           dtr_n,
  output logic                           rts_n,
  // Configuration out
  output uart_regs_pkg::uart_cfg_t       cfg,
  output logic                           rx_flush,
  output logic                           tx_flush
);
  logic [7:0] div_low_q;
  logic [7:0] div_high_q;
  logic [7:0] div_frac_q;
  logic [7:0] ier_q;
  logic [7:0] fcr_q;
  logic [7:0] lcr_q;
  logic [7:0] mcr_q;
  logic [7:0] spr_q;
  logic [7:0] feature_control_q;
  logic [7:0] efr_q;
  logic [7:0] r485_q;
  logic [3:0] delta_q;
  logic [3:0] modem_prev_q;
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic [3:0] modem_now;
  logic       dlab;
  logic       enh;
  logic       wr;
  logic       rd;
  logic [3:0] addr;
  logic [7:0] wd;
  logic       thr_push;
  logic       rhr_pop;
  logic       msr_read;
  logic [7:0] rx_head;
  logic       rx_avail;
  logic       tx_empty;
  logic [7:0] ier_wmask;
  logic [7:0] fcr_wmask;
  logic [7:0] mcr_wmask;
  logic [7:0] r485_wmask;
  logic [7:0] isr_val;
  logic [7:0] lsr_val;
  logic [7:0] rd_mux;
  logic       tx_in_ready;
  logic       tx_out_valid;

  assign dlab = lcr_q[uart_regs_pkg::LCR_DLAB_BIT];
  assign enh  = efr_q[uart_regs_pkg::EFR_ENH_BIT];
  assign wr   = req.wr;
  assign rd   = req.rd;
  assign addr = req.addr;
  assign wd   = req.wdata;

  // Data and modem status register side effects
  assign thr_push = wr && addr == uart_regs_pkg::OFS_DATA && !dlab;
  assign rhr_pop  = rd && addr == uart_regs_pkg::OFS_DATA && !dlab;
  assign msr_read = rd && addr == uart_regs_pkg::OFS_MODEM_ST;

  // Enhanced bits are writable only with enhanced enable set
  assign ier_wmask  = enh ? uart_regs_pkg::IER_MASK :
                      (uart_regs_pkg::IER_MASK & ~uart_regs_pkg::IER_ENH_MASK);
  assign fcr_wmask  = enh ? uart_regs_pkg::FCR_MASK :
                      (uart_regs_pkg::FCR_MASK & ~uart_regs_pkg::FCR_ENH_MASK);
  assign mcr_wmask  = enh ? 8'hff : ~uart_regs_pkg::MCR_ENH_MASK;
  assign r485_wmask = enh ? uart_regs_pkg::R485_MASK : 8'h00;

  // Transmit buffer between host writes and the transmitter
  sync_fifo #(
    .WIDTH (uart_regs_pkg::DATA_W),
    .DEPTH (uart_regs_pkg::FIFO_DEPTH)
  ) tx_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .flush     (tx_flush),
    .in_valid  (thr_push),
    .in_ready  (tx_in_ready),
    .in_data   (wd),
    .out_valid (tx_out_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  // Receive buffer between the receiver and host reads
  sync_fifo #(
    .WIDTH (uart_regs_pkg::DATA_W),
    .DEPTH (uart_regs_pkg::FIFO_DEPTH)
  ) rx_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .flush     (rx_flush),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   (rx_data),
    .out_valid (rx_avail),
    .out_ready (rhr_pop),
    .out_data  (rx_head)
  );

  assign thr_ready = tx_in_ready;
  assign tx_valid  = tx_out_valid;
  assign tx_empty  = !tx_out_valid;

  // Divisor registers behind the divisor access bit
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      div_low_q  <= uart_regs_pkg::DIV_LOW_RST;
      div_high_q <= uart_regs_pkg::DIV_HIGH_RST;
      div_frac_q <= uart_regs_pkg::DIV_FRAC_RST;
    end else if (wr && dlab) begin
      case (addr)
        uart_regs_pkg::OFS_DATA: div_low_q <= wd;
        uart_regs_pkg::OFS_IER:  div_high_q <= wd;
        uart_regs_pkg::OFS_ISR: begin
          div_frac_q <= wd & uart_regs_pkg::FRAC_MASK;
        end
        default: ;
      endcase
    end
  end

  // Interrupt enable and FIFO control
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ier_q <= uart_regs_pkg::IER_RST;
      fcr_q <= uart_regs_pkg::FCR_RST;
    end else begin
      if (wr && !dlab && addr == uart_regs_pkg::OFS_IER) begin
        ier_q <= wd & ier_wmask;
      end else if (!enh) begin
        ier_q <= ier_q & ~uart_regs_pkg::IER_ENH_MASK;
      end
      if (wr && !dlab && addr == uart_regs_pkg::OFS_ISR) begin
        fcr_q <= wd & fcr_wmask;
      end else if (!enh) begin
        fcr_q <= fcr_q & ~uart_regs_pkg::FCR_ENH_MASK;
      end
    end
  end

  // FIFO reset strobes, one cycle after the write
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rx_flush <= 1'b0;
      tx_flush <= 1'b0;
    end else begin
      rx_flush <= wr && !dlab && addr == uart_regs_pkg::OFS_ISR &&
                  wd[uart_regs_pkg::FCR_RXRST_BIT];
      tx_flush <= wr && !dlab && addr == uart_regs_pkg::OFS_ISR &&
                  wd[uart_regs_pkg::FCR_TXRST_BIT];
    end
  end

  // Line control, modem control and scratch
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lcr_q <= uart_regs_pkg::LCR_RST;
      mcr_q <= uart_regs_pkg::MCR_RST;
      spr_q <= uart_regs_pkg::SPR_RST;
    end else begin
      if (wr && addr == uart_regs_pkg::OFS_LINE_CTL) begin
        lcr_q <= wd;
      end
      if (wr && addr == uart_regs_pkg::OFS_MODEM_CT) begin
        mcr_q <= wd & mcr_wmask;
      end else if (!enh) begin
        mcr_q <= mcr_q & ~uart_regs_pkg::MCR_ENH_MASK;
      end
      if (wr && addr == uart_regs_pkg::OFS_SCRATCH) begin
        spr_q <= wd;
      end
    end
  end

  // Feature, enhanced function and RS-485 settings
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      feature_control_q <= uart_regs_pkg::FEATURE_CONTROL_RST;
      efr_q  <= uart_regs_pkg::EFR_RST;
      r485_q <= uart_regs_pkg::R485_RST;
    end else begin
      if (wr && addr == uart_regs_pkg::OFS_FEATURE) begin
        feature_control_q <= wd & uart_regs_pkg::FEATURE_CONTROL_MASK;
      end
      if (wr && addr == uart_regs_pkg::OFS_ENH_FUNC) begin
        efr_q <= wd;
      end
      if (wr && addr == uart_regs_pkg::OFS_MODEM_ST) begin
        r485_q <= wd & r485_wmask;
      end else if (!enh) begin
        r485_q <= uart_regs_pkg::R485_RST;
      end
    end
  end

  // Two-flop synchroniser for the modem pins
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end else begin
      pin_meta_q <= {~cd_n, ~ri_n, ~dsr_n, ~cts_n};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Loopback feeds modem control back as {CD, RI, DSR, CTS}
  always_comb begin
    if (mcr_q[uart_regs_pkg::MCR_LOOP_BIT]) begin
      modem_now = {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]};
    end else begin
      modem_now = pin_sync_q;
    end
  end

  // Delta flags: a change in the read cycle survives the clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      modem_prev_q <= 4'h0;
      delta_q      <= 4'h0;
    end else begin
      modem_prev_q <= modem_now;
      delta_q      <= (msr_read ? 4'h0 : delta_q) |
                      (modem_now ^ modem_prev_q);
    end
  end

  // Modem pins are inactive during loopback
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
    end else begin
      dtr_n <= ~mcr_q[0] | mcr_q[uart_regs_pkg::MCR_LOOP_BIT];
      rts_n <= ~mcr_q[1] | mcr_q[uart_regs_pkg::MCR_LOOP_BIT];
    end
  end

  // Interrupt status and line status views
  always_comb begin
    isr_val = {{2{fcr_q[uart_regs_pkg::FCR_EN_BIT]}},
               flow_change, xoff_special, int_source};
    if (!enh) begin
      isr_val = isr_val & ~uart_regs_pkg::ISR_ENH_MASK;
    end
    lsr_val = {line_flags.fifo_err, tx_empty && tx_shift_empty,
               tx_empty, line_flags.rx_break, line_flags.framing,
               line_flags.parity, line_flags.overrun, rx_avail};
  end

  // Read decode
  always_comb begin
    case (addr)
      uart_regs_pkg::OFS_DATA:     rd_mux = dlab ? div_low_q : rx_head;
      uart_regs_pkg::OFS_IER:      rd_mux = dlab ? div_high_q : ier_q;
      uart_regs_pkg::OFS_ISR:      rd_mux = dlab ? div_frac_q : isr_val;
      uart_regs_pkg::OFS_LINE_CTL: rd_mux = lcr_q;
      uart_regs_pkg::OFS_MODEM_CT: rd_mux = mcr_q;
      uart_regs_pkg::OFS_LINE_ST:  rd_mux = lsr_val;
      uart_regs_pkg::OFS_MODEM_ST: rd_mux = {modem_now, delta_q};
      uart_regs_pkg::OFS_SCRATCH:  rd_mux = spr_q;
      uart_regs_pkg::OFS_FEATURE:  rd_mux = feature_control_q;
      uart_regs_pkg::OFS_ENH_FUNC: rd_mux = efr_q;
      uart_regs_pkg::OFS_RSVD:     rd_mux = uart_regs_pkg::ZERO_BYTE;
      default:                     rd_mux = uart_regs_pkg::ZERO_BYTE;
    endcase
  end

  // Registered read answer
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_data  <= uart_regs_pkg::ZERO_BYTE;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd;
      if (rd) begin
        rd_data <= rd_mux;
      end
    end
  end

  // Configuration out
  assign cfg = '{div_low:    div_low_q,
                 div_high:   div_high_q,
                 div_frac:   div_frac_q,
                 int_enable: ier_q,
                 fifo_ctl:   fcr_q,
                 line_ctl:   lcr_q,
                 modem_ctl:  mcr_q,
                 feature:    feature_control_q,
                 enh_func:   efr_q,
                 rs485_mode: r485_q};
endmodule // uart_channel_register_map

// ---- testbench/uart_map_checker.sv ----
// Port-level rules of the channel register map
module uart_map_checker (
  // Clock and reset
  input wire logic                     sys_clk,
  input wire logic                     rstn,
  // Host side
  input wire uart_regs_pkg::host_req_t req,
  input wire logic                     rd_valid,
  input wire logic                     thr_ready,
  // Data and pins
  input wire logic                     tx_valid,
  input wire logic                     dtr_n,
  input wire logic                     rts_n,
  // Configuration
  input wire uart_regs_pkg::uart_cfg_t cfg,
  input wire logic                     rx_flush,
  input wire logic                     tx_flush
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Accepted data write and fifo control write
  sequence s_data_wr;
    req.wr && req.addr == 4'h0 && !cfg.line_ctl[7] && thr_ready;
  endsequence
  sequence s_fcr_wr;
    req.wr && req.addr == 4'h2 && !cfg.line_ctl[7];
  endsequence

  property p_rd_answer;
    req.rd |=> rd_valid;
  endproperty
  property p_frac;
    cfg.div_frac[7:4] == 4'h0;
  endproperty
  property p_enh_off;
    !cfg.enh_func[4] && !$past(cfg.enh_func[4]) |->
      cfg.int_enable[7:5] == 3'h0 && cfg.fifo_ctl[5:4] == 2'h0 &&
      cfg.modem_ctl[7:5] == 3'h0 && cfg.modem_ctl[3:2] == 2'h0 &&
      cfg.rs485_mode == 8'h00;
  endproperty
  property p_fixed_zero;
    (cfg.feature & 8'hcf) == 8'h00 && !cfg.int_enable[4];
  endproperty
  property p_div_high;
    req.wr && req.addr == 4'h1 && cfg.line_ctl[7] |=>
      cfg.div_high == $past(req.wdata);
  endproperty
  property p_flush;
    s_fcr_wr |=> rx_flush == $past(req.wdata[1]) &&
      tx_flush == $past(req.wdata[2]);
  endproperty
  property p_flush_cause;
    rx_flush || tx_flush |-> $past(req.wr && req.addr == 4'h2);
  endproperty
  property p_tx_load;
    s_data_wr |=> tx_valid;
  endproperty
  property p_ro_write;
    req.wr && (req.addr == 4'h5 || req.addr == 4'ha) |=> $stable(cfg);
  endproperty
  property p_pins;
    $stable(cfg.modem_ctl) |->
      dtr_n == (!cfg.modem_ctl[0] || cfg.modem_ctl[4]) &&
      rts_n == (!cfg.modem_ctl[1] || cfg.modem_ctl[4]);
  endproperty

  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");
  a_frac: assert property (p_frac)
    else $error("fraction high bits set");
  a_enh_off: assert property (p_enh_off)
    else $error("enhanced bits active while gated");
  a_fixed_zero: assert property (p_fixed_zero)
    else $error("fixed zero bit set");
  a_div_high: assert property (p_div_high)
    else $error("divisor high not written");
  a_flush: assert property (p_flush)
    else $error("flush pulse wrong");
  a_flush_cause: assert property (p_flush_cause)
    else $error("flush without write");
  a_tx_load: assert property (p_tx_load)
    else $error("data write not offered");
  a_ro_write: assert property (p_ro_write)
    else $error("read-only write changed state");
  a_pins: assert property (p_pins)
    else $error("modem pin level wrong");
endmodule // uart_map_checker

bind uart_channel_register_map uart_map_checker i_chk (
  .sys_clk, .rstn, .req, .rd_valid, .thr_ready, .tx_valid,
  .dtr_n, .rts_n, .cfg, .rx_flush, .tx_flush);

// ---- testbench/line_side_model.sv ----
// Transmitter sink and receiver source facing the channel
module line_side_model (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        stall,
  // Transmit stream
  input wire logic        tx_valid,
  output logic            tx_ready,
  input wire logic  [7:0] tx_data,
  // Receive stream
  output logic            rx_valid,
  input wire logic        rx_ready,
  output logic      [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  logic [7:0] got_q[$];

  // Sink takes a byte per cycle unless stalled
  assign tx_ready = !stall;
  always @(posedge sys_clk)
    if (rstn && tx_valid && tx_ready)
      got_q.push_back(tx_data);

  // Source holds a byte until taken; idle data toggles every cycle
  always @(posedge sys_clk) begin
    if (!rstn) begin
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else if (!rx_valid || rx_ready) begin
      if (rx_q.size() > 0) begin
        rx_valid <= 1'b1;
        rx_data  <= rx_q.pop_front();
      end else begin
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
      end
    end
  end
endmodule // line_side_model

// ---- testbench/uart_channel_register_map_tb_top.sv ----
// Self-checking bench for the channel register map
module uart_channel_register_map_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       sys_clk = 1'b0;
  logic                       rstn = 1'b0;
  uart_regs_pkg::host_req_t   req = '0;
  uart_regs_pkg::line_flags_t line_flags = '0;
  uart_regs_pkg::uart_cfg_t   cfg;
  logic [7:0] rd_data, tx_data, rx_data;
  logic [3:0] int_source = 4'h0;
  logic rd_valid, thr_ready, tx_valid, tx_ready, rx_valid, rx_ready;
  logic flow_change = 1'b0, xoff_special = 1'b0, stall = 1'b0;
  logic cts_n = 1'b1, dsr_n = 1'b1, ri_n = 1'b1, cd_n = 1'b1;
  logic dtr_n, rts_n, rx_flush, tx_flush;
  logic tx_shift_empty = 1'b1;
  int   num_errors = 0;
  int   n_checks = 0;

  // Clock of 100 ns period
  always #50 sys_clk = ~sys_clk;

  uart_channel_register_map i_dut (
    .sys_clk, .rstn, .req, .rd_data, .rd_valid, .thr_ready,
    .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data,
    .line_flags, .tx_shift_empty, .int_source, .flow_change,
    .xoff_special, .cts_n, .dsr_n, .ri_n, .cd_n, .dtr_n, .rts_n,
    .cfg, .rx_flush, .tx_flush);

  line_side_model i_far (
    .sys_clk, .rstn, .stall, .tx_valid, .tx_ready, .tx_data,
    .rx_valid, .rx_ready, .rx_data);

  task automatic end_sim;
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: got %h expected %h",
               $time, got, exp);
    end
  endtask

  // Host write, one idle cycle after
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    req <= '0;
    @(posedge sys_clk);
  endtask

  // Host read, answer compared in its valid cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    req <= '0;
    @(posedge sys_clk);
    chk({7'h00, rd_valid}, 8'h01);
    chk(rd_data, e);
  endtask

  task automatic t_reset;
    logic [3:0] ofs [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8,
                            4'h9, 4'ha};
    foreach (ofs[i])
      rd(ofs[i], 8'h00);
    rd(4'h5, 8'h60);
  endtask

  task automatic t_divisor;
    wr(4'h3, 8'h83);
    wr(4'h0, 8'ha5);
    wr(4'h1, 8'h5a);
    wr(4'h2, 8'hff);
    rd(4'h0, 8'ha5);
    rd(4'h1, 8'h5a);
    rd(4'h2, 8'h0f);
    rd(4'h3, 8'h83);
    wr(4'h3, 8'h03);
    rd(4'h1, 8'h00);
    rd(4'h3, 8'h03);
  endtask

  task automatic t_enhanced;
    wr(4'h1, 8'hff);
    rd(4'h1, 8'h0f);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'hff);
    wr(4'h1, 8'hff);
    rd(4'h1, 8'hef);
    wr(4'h4, 8'he0);
    rd(4'h4, 8'he0);
    wr(4'h9, 8'h00);
    rd(4'h1, 8'h0f);
    rd(4'h4, 8'h00);
    wr(4'h8, 8'hff);
    rd(4'h8, 8'h30);
    wr(4'h7, 8'h5a);
    rd(4'h7, 8'h5a);
    wr(4'ha, 8'hff);
    wr(4'h5, 8'h00);
    rd(4'ha, 8'h00);
    rd(4'h7, 8'h5a);
    wr(4'h1, 8'h00);
  endtask

  task automatic t_status;
    int_source <= 4'h6;
    flow_change <= 1'b1;
    xoff_special <= 1'b1;
    wr(4'h2, 8'hf9);
    chk(cfg.fifo_ctl, 8'hc9);
    rd(4'h2, 8'hc6);
    wr(4'h9, 8'h10);
    rd(4'h2, 8'hf6);
    wr(4'h6, 8'hff);
    chk(cfg.rs485_mode, 8'hfd);
    wr(4'h9, 8'h00);
    @(posedge sys_clk);
    chk(cfg.rs485_mode, 8'h00);
  endtask

  task automatic t_modem;
    cts_n <= 1'b0;
    cd_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rd(4'h6, 8'h99);
    cts_n <= 1'b1;
    cd_n <= 1'b1;
    dsr_n <= 1'b0;
    ri_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rd(4'h6, 8'h6f);
    rd(4'h6, 8'h60);
    wr(4'h4, 8'h01);
    @(posedge sys_clk);
    chk({6'h00, rts_n, dtr_n}, 8'h02);
    wr(4'h4, 8'h0e);
    @(posedge sys_clk);
    chk({6'h00, rts_n, dtr_n}, 8'h01);
    wr(4'h4, 8'h13);
    @(posedge sys_clk);
    chk({6'h00, rts_n, dtr_n}, 8'h03);
    wr(4'h4, 8'h00);
  endtask

  task automatic t_transmit;
    stall <= 1'b1;
    for (int i = 0; i < 9; i++)
      wr(4'h0, 8'h30 + 8'(i));
    chk({7'h00, thr_ready}, 8'h00);
    rd(4'h5, 8'h00);
    stall <= 1'b0;
    for (int k = 0; k < 60 && i_far.got_q.size() < 9; k++)
      @(posedge sys_clk);
    chk(8'(i_far.got_q.size()), 8'h08);
    foreach (i_far.got_q[i])
      chk(i_far.got_q[i], 8'h30 + 8'(i));
    i_far.got_q.delete();
    rd(4'h5, 8'h60);
    stall <= 1'b1;
    wr(4'h0, 8'haa);
    wr(4'h2, 8'h05);
    stall <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk(8'(i_far.got_q.size()), 8'h00);
  endtask

  task automatic t_receive;
    line_flags <= '{fifo_err: 1'b1, rx_break: 1'b1, framing: 1'b0,
                    parity: 1'b1, overrun: 1'b0};
    i_far.rx_q.push_back(8'h11);
    i_far.rx_q.push_back(8'h22);
    repeat (5) @(posedge sys_clk);
    rd(4'h5, 8'hf5);
    line_flags <= '0;
    rd(4'h0, 8'h11);
    rd(4'h0, 8'h22);
    rd(4'h5, 8'h60);
    for (int i = 0; i < 8; i++)
      i_far.rx_q.push_back(8'h40 + 8'(i));
    repeat (15) @(posedge sys_clk);
    chk({7'h00, rx_ready}, 8'h00);
    wr(4'h2, 8'h03);
    rd(4'h5, 8'h60);
  endtask

  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_divisor();
    t_enhanced();
    t_status();
    t_modem();
    t_transmit();
    t_receive();
    end_sim();
  end

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    end_sim();
  end
endmodule // uart_channel_register_map_tb_top
